// [src/atask_taskfile.sv]
/*
  task-file status, device control, drive address and command acceptance.
  assumes host strobes and the media engine run on clk; one strobe per cycle.
*/
`timescale 1ns/1ps
module atask_taskfile
  import atask_pkg::*;
#(
  parameter int DRQ2_LIMIT = DRQ2_CYC,
  parameter int DRQ3_LIMIT = DRQ3_CYC
)(
  input  wire logic            clk,
  input  wire logic            rst_n,
  input  wire logic [3:0]      hostAddr,
  input  wire logic [7:0]      hostWrData,
  input  wire logic            hostWr,
  input  wire logic            hostRd,
  output logic [7:0]           hostRdData,
  input  wire logic            cardDriveNum,
  input  wire logic            mediaReady,
  input  wire logic            mediaWriteFault,
  input  atask_media_type      media,
  output atask_cmd_type        cmdOut,
  output logic                 cmdStart,
  output logic                 interruptRequestOut,
  output logic                 cfgIntBit
);
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000, ST_ACCEPT = 3'b001, ST_WAITBUF = 3'b011,
    ST_XFER = 3'b010, ST_EXEC = 3'b110, ST_SRST = 3'b100
  } atask_state_type;

  atask_state_type state;
  atask_cmd_type   decoded;
  logic [7:0]      secCount;
  logic [7:0]      secNum;
  logic [7:0]      cylLow;
  logic [7:0]      cylHigh;
  logic [7:0]      drvHead;
  logic [7:0]      errReg;
  logic            ctlSoftReset;
  logic            ctlIntDisable;
  logic            drq;
  logic            corrected_error_flag;
  logic            err;
  logic            irqPending;
  logic            writing;
  logic [18:0]     waitCnt;
  logic            busy;
  logic [7:0]      statusByte;
  logic [7:0]      driveAddrByte;
  logic            selected;
  logic            wrCmd;
  logic            cmdAccept;
  logic            rdStatus;
  logic            irqEvent;
  logic            waitExpired;

  atask_cmd_decode u_decode (
    .code (hostWrData),
    .cmd  (decoded)
  );

  assign busy = (state == ST_ACCEPT) || (state == ST_WAITBUF) || (state == ST_EXEC)
             || (state == ST_SRST);
  // the drive bit alone decides, head bits never take part in selection
  assign selected = (drvHead[DH_DRV] == cardDriveNum);
  assign wrCmd = hostWr && (hostAddr == OFS_STATUS);
  // host side may not touch the command register while busy
  assign cmdAccept = wrCmd && !busy && selected;
  assign rdStatus = hostRd && (hostAddr == OFS_STATUS);
  assign irqEvent = (state == ST_WAITBUF && media.drqSet) || (state == ST_EXEC && media.done)
                 || (state == ST_XFER && media.done) || (state == ST_ACCEPT
                 && cmdOut.cls inside {CLS_NOP, CLS_BAD});
  assign waitExpired = (cmdOut.cls == CLS_TWO) ? (waitCnt >= 19'(DRQ2_LIMIT - 1))
                                               : (waitCnt >= 19'(DRQ3_LIMIT - 1));

  // index position bit is hard zero
  assign statusByte = busy ? {1'b1, 7'h00}
                           : {1'b0, mediaReady, mediaWriteFault, mediaReady, drq, corrected_error_flag,
                              1'b0, err};
  assign driveAddrByte = {1'b0, ~writing, ~drvHead[3:0],
                          ~(mediaReady && selected && cardDriveNum),
                          ~(mediaReady && selected && !cardDriveNum)};

  // device control takes writes whenever they come, busy or not
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctlSoftReset  <= 1'b0;
      ctlIntDisable <= 1'b0;
    end else if (hostWr && hostAddr == OFS_DEVCTL) begin
      ctlSoftReset  <= hostWrData[CTL_SRST];
      ctlIntDisable <= hostWrData[CTL_NIEN];
    end
  end

  // command sequencer
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state  <= ST_IDLE;
      cmdOut <= '0;
    end else if (ctlSoftReset) begin
      state <= ST_SRST;
    end else begin
      unique case (state)
        ST_IDLE, ST_XFER: begin
          if (cmdAccept) begin
            state  <= ST_ACCEPT;
            cmdOut <= decoded;
          end else if (state == ST_XFER && (media.xferDone || media.done)) begin
            state <= ST_IDLE;
          end
        end
        ST_ACCEPT: begin
          unique case (cmdOut.cls)
            CLS_TWO, CLS_THREE: state <= ST_WAITBUF;
            CLS_ONE:            state <= ST_EXEC;
            default:            state <= ST_IDLE;
          endcase
        end
        // busy drops in the same cycle drq rises, well inside the allowance
        ST_WAITBUF: begin
          if (media.drqSet) begin
            state <= ST_XFER;
          end else if (media.done || waitExpired) begin
            state <= ST_IDLE;
          end
        end
        ST_EXEC: begin
          if (media.drqSet) begin
            state <= ST_XFER;
          end else if (media.done) begin
            state <= ST_IDLE;
          end
        end
        ST_SRST: state <= ST_IDLE;
      endcase
    end
  end

  assign cmdStart = (state == ST_ACCEPT) && (cmdOut.cls inside {CLS_ONE, CLS_TWO, CLS_THREE});

  // buffer set-up watchdog; a late media engine ends in abort, never a hang
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      waitCnt <= '0;
    end else if (state == ST_WAITBUF) begin
      waitCnt <= waitCnt + 19'h1;
    end else begin
      waitCnt <= '0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      writing <= 1'b0;
    end else if (busy && state == ST_SRST) begin
      writing <= 1'b0;
    end else if (state == ST_ACCEPT) begin
      writing <= (cmdOut.cls == CLS_TWO) || (cmdOut.cls == CLS_THREE);
    end else if (state == ST_IDLE) begin
      writing <= 1'b0;
    end
  end

  // status flags
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      drq  <= 1'b0;
      corrected_error_flag <= 1'b0;
      err  <= 1'b0;
    end else if (state == ST_SRST) begin
      drq  <= 1'b0;
      corrected_error_flag <= 1'b0;
      err  <= 1'b0;
    end else if (cmdAccept) begin
      drq  <= 1'b0;
      corrected_error_flag <= media.corrected_error_flag; // a correction in the accept cycle still shows
      err  <= 1'b0;
    end else begin
      if ((state == ST_WAITBUF || state == ST_EXEC) && media.drqSet) begin
        drq <= 1'b1;
      end else if (state == ST_XFER && (media.xferDone || media.done)) begin
        drq <= 1'b0;
      end
      // a read keeps running after a corrected error
      if (media.corrected_error_flag) begin
        corrected_error_flag <= 1'b1;
      end
      if ((media.done && media.error) || (state == ST_ACCEPT && cmdOut.cls == CLS_BAD)
          || (state == ST_WAITBUF && waitExpired && !media.drqSet)) begin
        err <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      errReg <= DIAG_OK;
    end else if (state == ST_SRST) begin
      errReg <= DIAG_OK;
    end else if (cmdAccept) begin
      errReg <= 8'h00;
    end else if (media.done && media.error) begin
      errReg <= media.errCode;
    end else if ((state == ST_ACCEPT && cmdOut.cls == CLS_BAD)
                 || (state == ST_WAITBUF && waitExpired && !media.drqSet)) begin
      errReg <= ERR_ABORT;
    end
  end

  // command block: host loads only while not busy, media engine leaves fail address
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      secCount <= RST_SECCOUNT;
      secNum   <= 8'h00;
      cylLow   <= 8'h00;
      cylHigh  <= 8'h00;
      drvHead  <= RST_DRVHEAD;
    end else if (media.failLoad) begin
      secNum         <= media.failAddr[7:0];
      cylLow         <= media.failAddr[15:8];
      cylHigh        <= media.failAddr[23:16];
      drvHead[3:0]   <= media.failAddr[27:24];
    end else if (hostWr && !busy) begin
      unique case (hostAddr)
        OFS_SECCOUNT: secCount <= hostWrData;
        OFS_SECNUM:   secNum   <= hostWrData;
        OFS_CYLLOW:   cylLow   <= hostWrData;
        OFS_CYLHIGH:  cylHigh  <= hostWrData;
        OFS_DRVHEAD:  drvHead  <= hostWrData;
        default:      ;
      endcase
    end
  end

  // interrupt: completion event wins over a clearing status read
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irqPending <= 1'b0;
    end else if (irqEvent) begin
      irqPending <= 1'b1;
    end else if (rdStatus || state == ST_SRST) begin
      irqPending <= 1'b0;
    end
  end

  assign interruptRequestOut = irqPending && !ctlIntDisable;
  assign cfgIntBit = interruptRequestOut;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hostRdData <= 8'h00;
    end else if (hostRd) begin
      unique case (hostAddr)
        OFS_ERROR:    hostRdData <= errReg;
        OFS_SECCOUNT: hostRdData <= secCount;
        OFS_SECNUM:   hostRdData <= secNum;
        OFS_CYLLOW:   hostRdData <= cylLow;
        OFS_CYLHIGH:  hostRdData <= cylHigh;
        OFS_DRVHEAD:  hostRdData <= drvHead;
        OFS_STATUS,
        OFS_DEVCTL:   hostRdData <= statusByte;
        OFS_DRVADDR:  hostRdData <= driveAddrByte;
        default:      hostRdData <= 8'h00;
      endcase
    end
  end

  property p_busyAfterCmd;
    @(posedge clk) disable iff (!rst_n)
      (cmdAccept && !ctlSoftReset) |=> busy && statusByte[BIT_BUSY];
  endproperty
  a_busyAfterCmd: assert property (p_busyAfterCmd)
    else $error("busy not set after command");

  property p_idxZero;
    @(posedge clk) disable iff (!rst_n) statusByte[BIT_IDX] == 1'b0;
  endproperty
  a_idxZero: assert property (p_idxZero)
    else $error("index bit not zero");

  property p_drqDropsBusy;
    @(posedge clk) disable iff (!rst_n) $rose(drq) |-> !busy;
  endproperty
  a_drqDropsBusy: assert property (p_drqDropsBusy)
    else $error("busy still set with drq");

  property p_softReset;
    @(posedge clk) disable iff (!rst_n)
      ctlSoftReset |=> state == ST_SRST ##1 (errReg == DIAG_OK && !err && !drq);
  endproperty
  a_softReset: assert property (p_softReset)
    else $error("soft reset did not clear status");

  property p_irqGate;
    @(posedge clk) disable iff (!rst_n)
      (hostWr && hostAddr == OFS_DEVCTL && hostWrData[CTL_NIEN])
      |=> !interruptRequestOut && !cfgIntBit;
  endproperty
  a_irqGate: assert property (p_irqGate)
    else $error("interrupt not gated");

  property p_statusReadClears;
    @(posedge clk) disable iff (!rst_n) (rdStatus && !irqEvent) |=> !irqPending;
  endproperty
  a_statusReadClears: assert property (p_statusReadClears)
    else $error("status read left interrupt pending");

  property p_altReadKeeps;
    @(posedge clk) disable iff (!rst_n)
      (hostRd && hostAddr == OFS_DEVCTL && irqPending && state != ST_SRST) |=> irqPending;
  endproperty
  a_altReadKeeps: assert property (p_altReadKeeps)
    else $error("alternate read cleared interrupt");

  property p_newCmdClears;
    @(posedge clk) disable iff (!rst_n) cmdAccept |=> !drq && !err;
  endproperty
  a_newCmdClears: assert property (p_newCmdClears)
    else $error("drq or err survived new command");

  property p_headInvert;
    @(posedge clk) disable iff (!rst_n)
      (hostRd && hostAddr == OFS_DRVADDR) |=> hostRdData[5:2] == ~$past(drvHead[3:0]);
  endproperty
  a_headInvert: assert property (p_headInvert)
    else $error("drive address head bits wrong");

  property p_ctlWhileBusy;
    @(posedge clk) disable iff (!rst_n)
      (hostWr && hostAddr == OFS_DEVCTL && busy) |=> ctlIntDisable == $past(hostWrData[1]);
  endproperty
  a_ctlWhileBusy: assert property (p_ctlWhileBusy)
    else $error("control write lost while busy");

  property p_nopQuick;
    @(posedge clk) disable iff (!rst_n)
      (state == ST_ACCEPT && cmdOut.cls == CLS_NOP && !ctlSoftReset) |-> !cmdStart ##1 !busy;
  endproperty
  a_nopQuick: assert property (p_nopQuick)
    else $error("no-operation command not completed");

  property p_class2Xfer;
    @(posedge clk) state == ST_ACCEPT && cmdOut.cls == CLS_TWO ##[1:20] state == ST_XFER;
  endproperty
  c_class2Xfer: cover property (p_class2Xfer);

  property p_class1Done;
    @(posedge clk) state == ST_EXEC ##1 state == ST_IDLE;
  endproperty
  c_class1Done: cover property (p_class1Done);

  property p_softResetSeen;
    @(posedge clk) state == ST_SRST;
  endproperty
  c_softResetSeen: cover property (p_softResetSeen);
endmodule

// [pkg/atask_pkg.sv]
/*
  shared constants and types of the task-file status and command block.
  assumes a 20 MHz clock and a host controller on the same clock.
*/
package atask_pkg;
  localparam logic [3:0] OFS_ERROR     = 4'h1;
  localparam logic [3:0] OFS_SECCOUNT  = 4'h2;
  localparam logic [3:0] OFS_SECNUM    = 4'h3;
  localparam logic [3:0] OFS_CYLLOW    = 4'h4;
  localparam logic [3:0] OFS_CYLHIGH   = 4'h5;
  localparam logic [3:0] OFS_DRVHEAD   = 4'h6;
  localparam logic [3:0] OFS_STATUS    = 4'h7;
  localparam logic [3:0] OFS_DEVCTL    = 4'he;
  localparam logic [3:0] OFS_DRVADDR   = 4'hf;
  localparam int BIT_BUSY = 7;
  localparam int BIT_DRQ  = 3;
  localparam int BIT_CORRECTED_ERROR_FLAG = 2;
  localparam int BIT_IDX  = 1;
  localparam int BIT_ERR  = 0;
  localparam int CTL_SRST = 2;
  localparam int CTL_NIEN = 1;
  localparam int DH_DRV   = 4;
  localparam logic [7:0] RST_SECCOUNT = 8'h01;
  localparam logic [7:0] RST_DRVHEAD  = 8'ha0;
  localparam logic [7:0] DIAG_OK      = 8'h01;
  localparam logic [7:0] ERR_ABORT    = 8'h04;
  localparam int CLK_NS     = 50;
  localparam int BUSY_NS    = 400;
  localparam int DRQ2_US    = 700;
  localparam int DRQ3_MS    = 20;
  localparam int BUSY_CYC   = (BUSY_NS / CLK_NS < 1) ? 1 : BUSY_NS / CLK_NS;
  localparam int DRQ2_CYC   = DRQ2_US * 1000 / CLK_NS;
  localparam int DRQ3_CYC   = DRQ3_MS * 1000 * 1000 / CLK_NS;

  typedef enum logic [2:0] {
    CLS_BAD = 3'h0, CLS_ONE = 3'h1, CLS_TWO = 3'h2, CLS_THREE = 3'h3, CLS_NOP = 3'h4
  } atask_class_type;

  typedef struct packed {
    logic [7:0]      code;
    atask_class_type cls;
    logic            driveOnly;
  } atask_cmd_type;

  typedef struct packed {
    logic        drqSet;
    logic        xferDone;
    logic        done;
    logic        error;
    logic [7:0]  errCode;
    logic        corrected_error_flag;
    logic        failLoad;
    logic [27:0] failAddr;
  } atask_media_type;
endpackage

// [src/atask_cmd_decode.sv]
/*
  command code decoder: class and drive-only flag per code.
  assumes a code byte from the command register; purely combinational.
*/
`timescale 1ns/1ps
module atask_cmd_decode
  import atask_pkg::*;
(
  input  wire logic [7:0]    code,
  output atask_cmd_type      cmd
);
  always_comb begin
    cmd.code = code;
    cmd.driveOnly = 1'b1;
    cmd.cls = CLS_ONE;
    unique casez (code)
      8'h00: cmd.cls = CLS_NOP;
      8'hc5, 8'hcd, 8'h3c: begin
        cmd.cls = CLS_THREE;
        cmd.driveOnly = 1'b0;
      end
      8'h50, 8'hca, 8'h30, 8'h31, 8'h38: begin
        cmd.cls = CLS_TWO;
        cmd.driveOnly = 1'b0;
      end
      8'he8: cmd.cls = CLS_TWO;
      8'hc0, 8'h91, 8'hc8, 8'hc4, 8'h20, 8'h21, 8'h40, 8'h41, 8'h7?, 8'hf9, 8'hb0,
      8'h87: cmd.driveOnly = 1'b0;
      8'he5, 8'h98, 8'h90, 8'he7, 8'hec, 8'he3, 8'h97, 8'he1, 8'h95, 8'he4, 8'hf8,
      8'h1?, 8'h03, 8'hf6, 8'hf3, 8'hf4, 8'hf5, 8'hf1, 8'hf2, 8'hef, 8'hc6, 8'he6,
      8'h99, 8'he2, 8'h96, 8'he0, 8'h94: cmd.driveOnly = 1'b1;
      default: cmd.cls = CLS_BAD;
    endcase
  end
endmodule

// [verif/atask_host_model.sv]
/*
  host controller model: byte reads and writes on the task-file strobes.
  assumes the device answers reads one cycle after the taking edge.
*/
`timescale 1ns/1ps
module atask_host_model
  import atask_pkg::*;
(
  input  wire logic       clk,
  input  wire logic [7:0] hostRdData,
  output logic [3:0]      hostAddr,
  output logic [7:0]      hostWrData,
  output logic            hostWr,
  output logic            hostRd
);
  initial begin
    hostAddr   = 4'h0;
    hostWrData = 8'h00;
    hostWr     = 1'b0;
    hostRd     = 1'b0;
  end

  // caller keeps control bits 7..3 and 0 at zero, commands only when idle
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    hostAddr   <= a;
    hostWrData <= d;
    hostWr     <= 1'b1;
    @(posedge clk);
    hostWr     <= 1'b0;
    hostWrData <= ~d; // released bus must not show the last byte
  endtask

  // drive address read only here, no other device shares its bit 7
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk);
    hostAddr <= a;
    hostRd   <= 1'b1;
    @(posedge clk);
    hostRd   <= 1'b0;
    @(posedge clk);
    #1;
    d = hostRdData;
  endtask
endmodule

// [verif/ata_taskfile_status_command_bench.sv]
/*
  self-checking bench of the task-file block, media engine driven here.
  assumes shortened watchdogs: 20 and 40 cycles.
*/
`timescale 1ns/1ps
module ata_taskfile_status_command_bench;
  import atask_pkg::*;
  localparam atask_media_type M_DRQ  = '{drqSet: 1'b1, default: '0};
  localparam atask_media_type M_XFER = '{xferDone: 1'b1, default: '0};
  localparam atask_media_type M_DONE = '{done: 1'b1, default: '0};
  localparam atask_media_type M_CORRECTED_ERROR_FLAG = '{corrected_error_flag: 1'b1, default: '0};
  logic            clk = 1'b0;
  logic            rst_n = 1'b0;
  logic            cardDriveNum = 1'b0;
  logic            mediaReady = 1'b1;
  logic            mediaWriteFault = 1'b0;
  atask_media_type media = '0;
  logic [3:0]      hostAddr;
  logic [7:0]      hostWrData;
  logic [7:0]      hostRdData;
  logic            hostWr;
  logic            hostRd;
  atask_cmd_type   cmdOut;
  logic            cmdStart;
  logic            interruptRequestOut;
  logic            cfgIntBit;
  int              errors = 0;
  int              checks = 0;
  int              cycles = 0;
  int              starts = 0;
  logic [7:0]      v;

  always #25 clk = ~clk;

  atask_taskfile #(.DRQ2_LIMIT(20), .DRQ3_LIMIT(40)) u_dut (
    .clk(clk), .rst_n(rst_n), .hostAddr(hostAddr), .hostWrData(hostWrData),
    .hostWr(hostWr), .hostRd(hostRd), .hostRdData(hostRdData),
    .cardDriveNum(cardDriveNum), .mediaReady(mediaReady),
    .mediaWriteFault(mediaWriteFault), .media(media), .cmdOut(cmdOut),
    .cmdStart(cmdStart), .interruptRequestOut(interruptRequestOut),
    .cfgIntBit(cfgIntBit)
  );

  atask_host_model u_host (
    .clk(clk), .hostRdData(hostRdData), .hostAddr(hostAddr),
    .hostWrData(hostWrData), .hostWr(hostWr), .hostRd(hostRd)
  );

  task automatic print_verdict();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // whole run needs a few hundred cycles
  always @(posedge clk) begin
    cycles++;
    if (cmdStart === 1'b1) begin
      starts++;
    end
    if (cycles == 20000) begin
      errors++;
      print_verdict();
    end
  end

  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    checks++;
    if (g !== e) begin
      errors++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic rdchk(input logic [3:0] a, input logic [7:0] e, input string n);
    u_host.rd(a, v);
    chk(n, e, v);
  endtask

  task automatic irq(input logic e);
    @(posedge clk);
    #1;
    chk("irq", {7'h0, e}, {7'h0, interruptRequestOut});
    chk("cfgint", {7'h0, e}, {7'h0, cfgIntBit});
  endtask

  task automatic mp(input atask_media_type m);
    @(posedge clk);
    media <= m;
    @(posedge clk);
    media <= '0;
  endtask

  task automatic t_reset();
    rdchk(OFS_STATUS, 8'h50, "status");
    rdchk(OFS_DEVCTL, 8'h50, "altstatus");
    rdchk(OFS_DRVADDR, 8'h7e, "drvaddr");
    rdchk(OFS_ERROR, DIAG_OK, "error");
    u_host.wr(OFS_DRVHEAD, 8'ha5);
    rdchk(OFS_DRVADDR, 8'h6a, "drvaddr");
    @(posedge clk);
    mediaReady      <= 1'b0;
    mediaWriteFault <= 1'b1;
    rdchk(OFS_STATUS, 8'h20, "status");
    rdchk(OFS_DRVADDR, 8'h6b, "drvaddr");
    @(posedge clk);
    mediaReady      <= 1'b1;
    mediaWriteFault <= 1'b0;
    u_host.wr(OFS_DRVHEAD, RST_DRVHEAD);
  endtask

  task automatic t_class2();
    int n;
    n = starts;
    u_host.wr(OFS_STATUS, 8'h30);
    rdchk(OFS_STATUS, 8'h80, "busy");
    chk("class", 8'(CLS_TWO), 8'(cmdOut.cls));
    mp(M_DRQ);
    irq(1'b1);
    rdchk(OFS_DEVCTL, 8'h58, "altstatus");
    irq(1'b1);
    rdchk(OFS_DRVADDR, 8'h3e, "drvaddr");
    rdchk(OFS_STATUS, 8'h58, "status");
    irq(1'b0);
    mp(M_XFER);
    irq(1'b0);
    rdchk(OFS_STATUS, 8'h50, "status");
    chk("starts", 8'(n + 1), 8'(starts));
  endtask

  task automatic t_classes();
    logic [7:0]      codes [14] = '{8'hc5, 8'hcd, 8'h3c, 8'h30, 8'h31, 8'h38, 8'hca,
                                    8'he8, 8'h50, 8'hc4, 8'hf8, 8'hf9, 8'hec, 8'h20};
    atask_class_type c;
    for (int i = 0; i < 14; i++) begin
      c = (i < 3) ? CLS_THREE : (i < 9) ? CLS_TWO : CLS_ONE;
      u_host.wr(OFS_STATUS, codes[i]);
      rdchk(OFS_STATUS, 8'h80, "busy");
      chk("class", 8'(c), 8'(cmdOut.cls));
      chk("code", codes[i], cmdOut.code);
      if (c != CLS_ONE) begin
        mp(M_DRQ);
        rdchk(OFS_STATUS, 8'h58, "drq");
      end
      mp(M_DONE);
      irq(1'b1);
      rdchk(OFS_STATUS, 8'h50, "status");
    end
  endtask

  task automatic t_abort();
    u_host.wr(OFS_STATUS, 8'hc5);
    repeat (60) @(posedge clk);
    rdchk(OFS_STATUS, 8'h51, "status");
    rdchk(OFS_ERROR, ERR_ABORT, "error");
    u_host.wr(OFS_STATUS, 8'h02);
    repeat (2) @(posedge clk);
    irq(1'b1);
    rdchk(OFS_STATUS, 8'h51, "status");
    rdchk(OFS_ERROR, ERR_ABORT, "error");
    u_host.wr(OFS_STATUS, 8'hec);
    mp(M_DONE);
    rdchk(OFS_STATUS, 8'h50, "status");
  endtask

  task automatic t_fail();
    u_host.wr(OFS_STATUS, 8'h20);
    mp(M_CORRECTED_ERROR_FLAG);
    mp('{failLoad: 1'b1, failAddr: 28'h1234567, default: '0});
    mp('{done: 1'b1, error: 1'b1, errCode: 8'h40, default: '0});
    rdchk(OFS_STATUS, 8'h55, "status");
    rdchk(OFS_ERROR, 8'h40, "error");
    rdchk(OFS_SECNUM, 8'h67, "secnum");
    rdchk(OFS_CYLLOW, 8'h45, "cyllow");
    rdchk(OFS_CYLHIGH, 8'h23, "cylhigh");
  endtask

  task automatic t_devctl();
    u_host.wr(OFS_DEVCTL, 8'h04);
    rdchk(OFS_STATUS, 8'h80, "busy");
    u_host.wr(OFS_DEVCTL, 8'h00);
    rdchk(OFS_STATUS, 8'h50, "status");
    rdchk(OFS_ERROR, DIAG_OK, "error");
    u_host.wr(OFS_STATUS, 8'hec);
    u_host.wr(OFS_DEVCTL, 8'h02);
    mp(M_DONE);
    irq(1'b0);
    u_host.wr(OFS_DEVCTL, 8'h00);
    irq(1'b1);
    rdchk(OFS_STATUS, 8'h50, "status");
  endtask

  task automatic t_drive_nop();
    int n;
    u_host.wr(OFS_DRVHEAD, 8'hb0);
    u_host.wr(OFS_STATUS, 8'he5);
    rdchk(OFS_STATUS, 8'h50, "status");
    rdchk(OFS_DRVADDR, 8'h7f, "drvaddr");
    u_host.wr(OFS_DRVHEAD, 8'haf);
    u_host.wr(OFS_STATUS, 8'he5);
    rdchk(OFS_STATUS, 8'h80, "busy");
    chk("driveonly", 8'h01, {7'h0, cmdOut.driveOnly});
    mp(M_DONE);
    rdchk(OFS_STATUS, 8'h50, "status");
    n = starts;
    u_host.wr(OFS_STATUS, 8'h00);
    repeat (4) @(posedge clk);
    irq(1'b1);
    chk("starts", 8'(n), 8'(starts));
    rdchk(OFS_STATUS, 8'h50, "status");
  endtask

  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_class2();
    t_classes();
    t_abort();
    t_fail();
    t_devctl();
    t_drive_nop();
    print_verdict();
  end
endmodule
